// ### logic/hips_top.sv
// digital control of the hot-insertion supply controller.
// assumes comparator flags and pins are asynchronous; register port on clk_i.
`timescale 1ns/1ps
`include "hips_consts.svh"

module hips_top
(
   input  wire logic                    clk_i,           // 50 MHz clock
   input  wire logic                    rst_i,           // power-on reset, high
   input  wire logic                    board_select_line_i, // off/on pin, high = off
   input  wire logic                    backplane_reset_in_n_i, // backplane reset
   input  wire logic                    card_present_a_n_i, // present detect a
   input  wire logic                    card_present_b_n_i, // present detect b
   input  wire logic [`HIPS_NSUP-1:0]   undervolt_i,     // input uv flags
   input  wire logic [`HIPS_NSUP-1:0]   supply_in_tol_i, // output within pg limit
   input  wire logic [`HIPS_NSUP-1:0]   overcurrent_i,   // current-limit flags
   input  wire logic                    timer_done_i,    // timer above threshold
   input  wire logic                    fault_n_i,       // fault pin level
   output logic                         fault_n_o,       // fault pin drive value
   output logic                         fault_n_oe_o,    // fault pin pull low
   input  wire logic                    supplies_good_n_i, // power-good pin level
   output logic                         supplies_good_n_o, // power-good drive value
   output logic                         supplies_good_n_oe_o, // power-good pull low
   input  wire logic                    board_reset_out_n_i, // reset pin level
   output logic                         board_reset_out_n_o, // reset drive value
   output logic                         board_reset_out_n_oe_o, // reset pull low
   output logic                         status_led_n_o,  // led drive value
   output logic                         status_led_n_oe_o, // led pull low
   output logic                         bus_isolate_enable_o, // bus isolation
   output logic                         gate_charge_o,   // gate source on
   output logic                         gate_ground_o,   // gate hard pull to ground
   output logic                         switch_12v_on_o, // internal 12 V switch
   output logic                         switch_vee_on_o, // internal -12 V switch
   output logic                         timer_hold_o,    // timer held discharged
   output logic [`HIPS_NSUP-1:0]        out_discharge_o, // output discharge paths
   input  wire logic [`HIPS_ADDR_W-1:0] addr_i,          // register address
   input  wire logic [`HIPS_DATA_W-1:0] wdata_i,         // write data
   input  wire logic                    wr_i,            // write strobe
   input  wire logic                    rd_i,            // read strobe
   output logic [`HIPS_DATA_W-1:0]      rdata_o          // read data, next cycle
);

   // ==========================================================================
   // state and helpers
   hips_pkg::hips_regs_t    r;
   hips_pkg::hips_regs_t    next_r;
   logic [`HIPS_PIN_W-1:0]  pins;
   logic [`HIPS_NSUP-1:0]   oc_mask;
   logic [`HIPS_NSUP-1:0]   oc_hit;
   logic                    off_req;
   logic                    uv_any;
   logic                    all_ok;
   logic                    oc_live;
   logic                    trip;
   logic [1:0]              hit_idx;
   logic                    rst_low;

   assign pins = {board_reset_out_n_i, supplies_good_n_i, fault_n_i, timer_done_i,
                  overcurrent_i, supply_in_tol_i, undervolt_i, card_present_b_n_i,
                  card_present_a_n_i, backplane_reset_in_n_i, board_select_line_i};

   // ==========================================================================
   // next state
   always_comb
   begin
      next_r      = r;
      next_r.s1   = pins;
      next_r.s2   = r.s1;
      oc_mask     = r.ctrl[`HIPS_CTRL_IGN12] ? `HIPS_OC_MASK_LOW : `HIPS_OC_MASK_ALL;
      oc_hit      = r.s2[`HIPS_PIN_OC_LO +: `HIPS_NSUP] & oc_mask;
      off_req     = r.s2[`HIPS_PIN_BSEL] | r.ctrl[`HIPS_CTRL_OFF];
      uv_any      = |r.s2[`HIPS_PIN_UV_LO +: `HIPS_NSUP];
      all_ok      = &r.s2[`HIPS_PIN_OK_LO +: `HIPS_NSUP];
      // faults only count once the inhibit timer is done
      oc_live     = (r.st == hips_pkg::HIPS_ST_ON) && r.s2[`HIPS_PIN_TDONE]
                    && (|oc_hit);
      trip        = oc_live
                    && (r.oc_cnt == `HIPS_CNT_W'(`HIPS_OC_CYCLES - 1));
      // persistence counter restarts as soon as the fault clears
      next_r.oc_cnt = oc_live ? r.oc_cnt + `HIPS_CNT_ONE : `HIPS_CNT_ZERO;
      // lowest numbered failing supply wins
      hit_idx     = 2'h0;
      for (int i = `HIPS_NSUP - 1; i >= 0; i--)
      begin
         if (oc_hit[i])
         begin
            hit_idx = 2'(i);
         end
      end

      // sequencer
      case (r.st)
         hips_pkg::HIPS_ST_OFF:
         begin
            if (!off_req && !uv_any)
            begin
               next_r.st = hips_pkg::HIPS_ST_ON;
            end
         end
         hips_pkg::HIPS_ST_ON:
         begin
            if (trip)
            begin
               next_r.st   = hips_pkg::HIPS_ST_TRIP;
               next_r.code = hit_idx;
            end
            else if (off_req || uv_any)
            begin
               next_r.st = hips_pkg::HIPS_ST_OFF;
            end
         end
         hips_pkg::HIPS_ST_TRIP:
         begin
            // high half of the off/on cycle; the low half restarts from off
            if (off_req)
            begin
               next_r.st = hips_pkg::HIPS_ST_OFF;
            end
         end
         default:
         begin
            next_r.st = hips_pkg::HIPS_ST_OFF;
         end
      endcase

      // power-good deglitch
      if (all_ok)
      begin
         next_r.pg     = 1'b1;
         next_r.dg_cnt = `HIPS_CNT_ZERO;
      end
      else if (r.pg)
      begin
         if (r.dg_cnt == `HIPS_CNT_W'(`HIPS_DG_CYCLES - 1))
         begin
            next_r.pg     = 1'b0;
            next_r.dg_cnt = `HIPS_CNT_ZERO;
         end
         else
         begin
            next_r.dg_cnt = r.dg_cnt + `HIPS_CNT_ONE;
         end
      end
      else
      begin
         next_r.dg_cnt = `HIPS_CNT_ZERO;
      end

      // register port
      if (wr_i && (addr_i == `HIPS_ADDR_CTRL))
      begin
         next_r.ctrl = wdata_i[`HIPS_CTRL_W-1:0];
      end
      next_r.rdata = `HIPS_RDATA_ZERO;
      if (rd_i)
      begin
         case (addr_i)
            `HIPS_ADDR_CTRL:
            begin
               next_r.rdata = {{(`HIPS_DATA_W - `HIPS_CTRL_W){1'b0}}, r.ctrl};
            end
            `HIPS_ADDR_STAT:
            begin
               next_r.rdata = {r.code, r.s2[`HIPS_PIN_PRB], r.s2[`HIPS_PIN_PRA],
                               r.s2[`HIPS_PIN_PG], r.s2[`HIPS_PIN_RSTOUT],
                               r.s2[`HIPS_PIN_RSTIN], r.s2[`HIPS_PIN_FAULT]};
            end
            default:
            begin
               next_r.rdata = `HIPS_RDATA_ZERO;
            end
         endcase
      end

      // outputs from the next state
      rst_low          = !next_r.pg || !r.s2[`HIPS_PIN_RSTIN]
                         || next_r.ctrl[`HIPS_CTRL_RST];
      next_r.od_zero   = 1'b0;
      next_r.fault_oe  = (next_r.st == hips_pkg::HIPS_ST_TRIP);
      next_r.gate_gnd  = (next_r.st == hips_pkg::HIPS_ST_TRIP);
      next_r.pg_oe     = next_r.pg;
      next_r.be        = !next_r.pg;
      next_r.rst_oe    = rst_low;
      next_r.led_oe    = rst_low || next_r.ctrl[`HIPS_CTRL_LED];
      next_r.sw_on     = (next_r.st == hips_pkg::HIPS_ST_ON);
      next_r.gate_chg  = (next_r.st == hips_pkg::HIPS_ST_ON);
      next_r.tmr_hold  = (next_r.st != hips_pkg::HIPS_ST_ON);
      next_r.disch     = (next_r.st == hips_pkg::HIPS_ST_ON) ? `HIPS_DISCH_NONE
                                                             : `HIPS_DISCH_ALL;
   end

   // ==========================================================================
   // state register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         r          <= '0;
         // synchroniser starts deselected, so no power-on pulse after reset
         r.s1[`HIPS_PIN_BSEL] <= 1'b1;
         r.s2[`HIPS_PIN_BSEL] <= 1'b1;
         r.st       <= hips_pkg::HIPS_ST_OFF;
         r.ctrl     <= `HIPS_CTRL_RESET;
         r.rst_oe   <= 1'b1;
         r.led_oe   <= 1'b1;
         r.be       <= 1'b1;
         r.tmr_hold <= 1'b1;
         r.disch    <= `HIPS_DISCH_ALL;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign fault_n_o              = r.od_zero;
   assign fault_n_oe_o           = r.fault_oe;
   assign supplies_good_n_o      = r.od_zero;
   assign supplies_good_n_oe_o   = r.pg_oe;
   assign board_reset_out_n_o    = r.od_zero;
   assign board_reset_out_n_oe_o = r.rst_oe;
   assign status_led_n_o         = r.od_zero;
   assign status_led_n_oe_o      = r.led_oe;
   assign bus_isolate_enable_o   = r.be;
   assign gate_charge_o          = r.gate_chg;
   assign gate_ground_o          = r.gate_gnd;
   assign switch_12v_on_o        = r.sw_on;
   assign switch_vee_on_o        = r.sw_on;
   assign timer_hold_o           = r.tmr_hold;
   assign out_discharge_o        = r.disch;
   assign rdata_o                = r.rdata;

   // ==========================================================================
   // assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_on_early;
      (r.st == hips_pkg::HIPS_ST_ON) && !r.s2[`HIPS_PIN_TDONE];
   endsequence

   sequence s_oc_full;
      oc_live && (r.oc_cnt == `HIPS_CNT_W'(`HIPS_OC_CYCLES - 1));
   endsequence

   sequence s_trip_wait;
      (r.st == hips_pkg::HIPS_ST_TRIP) && !off_req;
   endsequence

   sequence s_good_lost;
      r.pg && !all_ok && (r.dg_cnt != `HIPS_CNT_W'(`HIPS_DG_CYCLES - 1));
   endsequence

   inhibit_ignore_a : assert property (s_on_early |=> !fault_n_oe_o)
      else $error("fault raised before inhibit timer done");

   oc_trip_fault_a : assert property (s_oc_full |=> fault_n_oe_o && !switch_12v_on_o
                                      && !gate_charge_o)
      else $error("overcurrent trip did not fault and turn off");

   trip_latched_a : assert property (s_trip_wait |=> fault_n_oe_o && !gate_charge_o)
      else $error("tripped state left without off/on cycle");

   gate_ground_a : assert property (fault_n_oe_o |-> gate_ground_o && !gate_charge_o)
      else $error("gate not grounded while tripped");

   timer_hold_a : assert property (!switch_12v_on_o |-> timer_hold_o)
      else $error("inhibit timer released while off");

   pg_only_good_a : assert property ($rose(supplies_good_n_oe_o)
                                     |-> $past(all_ok))
      else $error("power good asserted with a supply out of tolerance");

   pg_deglitch_a : assert property (s_good_lost |=> supplies_good_n_oe_o)
      else $error("power good dropped without deglitch");

   pg_no_off_a : assert property ((r.st == hips_pkg::HIPS_ST_ON) && !all_ok && !trip
                                  && !off_req && !uv_any |=> switch_12v_on_o)
      else $error("loss of power good turned supplies off");

   be_follow_a : assert property (bus_isolate_enable_o != supplies_good_n_oe_o)
      else $error("bus isolation not opposite to power good");

   reset_combine_a : assert property (!r.pg || r.ctrl[`HIPS_CTRL_RST]
                                      |-> board_reset_out_n_oe_o)
      else $error("board reset not asserted");

   led_reset_a : assert property (board_reset_out_n_oe_o |-> status_led_n_oe_o)
      else $error("led dark while board reset low");

   recover_a : assert property ((r.st == hips_pkg::HIPS_ST_TRIP) && off_req
                                |=> !fault_n_oe_o)
      else $error("off command did not clear a trip");

   uv_off_a : assert property (uv_any |=> !switch_12v_on_o)
      else $error("switches on during undervoltage");

   discharge_a : assert property (!switch_12v_on_o |-> out_discharge_o
                                  == `HIPS_DISCH_ALL)
      else $error("discharge off while switches off");

   on_no_disch_a : assert property (switch_12v_on_o |-> out_discharge_o
                                    == `HIPS_DISCH_NONE)
      else $error("discharge on while switches on");

   timer_release_a : assert property (switch_12v_on_o |-> !timer_hold_o)
      else $error("inhibit timer held while on");

   off_pin_a : assert property (r.s2[`HIPS_PIN_BSEL]
                                |=> !switch_12v_on_o && !gate_charge_o)
      else $error("off request left supplies on");

   reset_backplane_a : assert property (!r.s2[`HIPS_PIN_RSTIN]
                                        |=> board_reset_out_n_oe_o)
      else $error("backplane reset not passed to board reset");

   reset_release_a : assert property (!board_reset_out_n_oe_o
                                      |-> r.pg && !r.ctrl[`HIPS_CTRL_RST])
      else $error("board reset released without power good");

   oc_restart_a : assert property (!oc_live |=> r.oc_cnt == `HIPS_CNT_ZERO)
      else $error("overcurrent counter did not restart");

   pg_drop_a : assert property ($fell(supplies_good_n_oe_o)
                                |-> $past(r.dg_cnt)
                                == `HIPS_CNT_W'(`HIPS_DG_CYCLES - 1))
      else $error("power good dropped before deglitch time");

   code_hold_a : assert property (!trip |=> $stable(r.code))
      else $error("fault code changed without a trip");

endmodule

// ### logic/hips_consts.svh
// constants of the hot-insertion power sequencer: timing, pin vector layout,
// register offsets and control bit positions.
// assumes a 50 MHz system clock.
`ifndef HIPS_CONSTS_SVH
`define HIPS_CONSTS_SVH

// ==========================================================================
// timing
`define HIPS_CLK_PERIOD_NS 20
`define HIPS_OC_TIME_NS    35000
`define HIPS_DG_TIME_NS    10000
// least times, rounded up to whole cycles
`define HIPS_OC_CYCLES ((`HIPS_OC_TIME_NS + `HIPS_CLK_PERIOD_NS - 1) / `HIPS_CLK_PERIOD_NS)
`define HIPS_DG_CYCLES ((`HIPS_DG_TIME_NS + `HIPS_CLK_PERIOD_NS - 1) / `HIPS_CLK_PERIOD_NS)
`define HIPS_CNT_W     11
`define HIPS_CNT_ZERO  11'h000
`define HIPS_CNT_ONE   11'h001

// ==========================================================================
// synchronised pin vector layout
`define HIPS_PIN_BSEL   0
`define HIPS_PIN_RSTIN  1
`define HIPS_PIN_PRA    2
`define HIPS_PIN_PRB    3
`define HIPS_PIN_UV_LO  4
`define HIPS_PIN_OK_LO  8
`define HIPS_PIN_OC_LO  12
`define HIPS_PIN_TDONE  16
`define HIPS_PIN_FAULT  17
`define HIPS_PIN_PG     18
`define HIPS_PIN_RSTOUT 19
`define HIPS_PIN_W      20
`define HIPS_NSUP       4

// ==========================================================================
// register bus
`define HIPS_ADDR_W     4
`define HIPS_DATA_W     8
`define HIPS_ADDR_CTRL  4'h0
`define HIPS_ADDR_STAT  4'h1
`define HIPS_RDATA_ZERO 8'h00
`define HIPS_CTRL_OFF   0
`define HIPS_CTRL_RST   1
`define HIPS_CTRL_LED   2
`define HIPS_CTRL_IGN12 3
`define HIPS_CTRL_W     4
`define HIPS_CTRL_RESET 4'h0
// overcurrent masks: bits 2 and 3 are the 12 V and -12 V supplies
`define HIPS_OC_MASK_ALL 4'hf
`define HIPS_OC_MASK_LOW 4'h3
`define HIPS_DISCH_ALL   4'hf
`define HIPS_DISCH_NONE  4'h0

`endif

// ### logic/hips_pkg.sv
// types of the hot-insertion power sequencer.
// assumes hips_consts.svh is on the include path.
`include "hips_consts.svh"

package hips_pkg;

   // ==========================================================================
   // sequencer states
   typedef enum logic [2:0]
   {
      HIPS_ST_OFF  = 3'b001,
      HIPS_ST_ON   = 3'b010,
      HIPS_ST_TRIP = 3'b100
   } hips_state_t;

   // ==========================================================================
   // whole state of the block
   typedef struct packed
   {
      logic [`HIPS_PIN_W-1:0]  s1;
      logic [`HIPS_PIN_W-1:0]  s2;
      hips_state_t             st;
      logic [`HIPS_CNT_W-1:0]  oc_cnt;
      logic [`HIPS_CNT_W-1:0]  dg_cnt;
      logic                    pg;
      logic [1:0]              code;
      logic [`HIPS_CTRL_W-1:0] ctrl;
      logic [`HIPS_DATA_W-1:0] rdata;
      logic                    od_zero;
      logic                    fault_oe;
      logic                    pg_oe;
      logic                    rst_oe;
      logic                    led_oe;
      logic                    be;
      logic                    gate_chg;
      logic                    gate_gnd;
      logic                    sw_on;
      logic                    tmr_hold;
      logic [`HIPS_NSUP-1:0]   disch;
   } hips_regs_t;

endpackage

// ### verif/hips_backplane.sv
// backplane side of the sequencer: board select, backplane reset, present
// detect and the pulled-up open-drain lines read back by the block.
// assumes requests from the bench change just after a rising clock edge.
`timescale 1ns/1ps

module hips_backplane
(
   input  wire logic clk_i,                  // system clock
   input  wire logic off_req_i,              // ask for board power off
   input  wire logic bp_reset_req_i,         // ask for backplane reset
   input  wire logic present_a_i,            // present a level
   input  wire logic present_b_i,            // present b level
   input  wire logic fault_drv_i,            // fault drive value
   input  wire logic fault_oe_i,             // fault pull low
   input  wire logic pg_drv_i,               // power-good drive value
   input  wire logic pg_oe_i,                // power-good pull low
   input  wire logic rst_drv_i,              // board reset drive value
   input  wire logic rst_oe_i,               // board reset pull low
   output logic      board_select_line_o,    // off/on pin, high = off
   output logic      backplane_reset_in_n_o, // backplane reset, low active
   output logic      card_present_a_n_o,     // present detect a
   output logic      card_present_b_n_o,     // present detect b
   output logic      fault_n_o,              // fault line level
   output logic      supplies_good_n_o,      // power-good line level
   output logic      board_reset_out_n_o     // board reset line level
);
   // ==========================================================================
   // board select and backplane reset
   logic sel = 1'b1;
   logic bp  = 1'b1;

   always_ff @(posedge clk_i)
   begin
      sel <= off_req_i;
      bp  <= !bp_reset_req_i;
   end

   // ==========================================================================
   // pin levels, open-drain lines pulled up
   assign board_select_line_o    = sel;
   assign backplane_reset_in_n_o = bp;
   assign card_present_a_n_o     = present_a_i;
   assign card_present_b_n_o     = present_b_i;
   assign fault_n_o              = fault_oe_i ? fault_drv_i : 1'b1;
   assign supplies_good_n_o      = pg_oe_i ? pg_drv_i : 1'b1;
   assign board_reset_out_n_o    = rst_oe_i ? rst_drv_i : 1'b1;
endmodule

// ### verif/test_hot_insert_power_sequencer.sv
// self-checking bench of the hot-insertion power sequencer.
// assumes hips_consts.svh on the include path and the backplane model.
`timescale 1ns/1ps
`include "hips_consts.svh"

module test_hot_insert_power_sequencer;
   localparam int OC = `HIPS_OC_CYCLES;
   localparam int DG = `HIPS_DG_CYCLES;
   logic                    clk_i = 1'b0;
   logic                    rst_i = 1'b1;
   logic                    off_req = 1'b1;
   logic                    bp_req = 1'b0;
   logic                    pres_a = 1'b1;
   logic                    pres_b = 1'b1;
   logic [`HIPS_NSUP-1:0]   undervolt_i = 4'h0;
   logic [`HIPS_NSUP-1:0]   supply_in_tol_i = 4'h0;
   logic [`HIPS_NSUP-1:0]   overcurrent_i = 4'h0;
   logic                    timer_done_i = 1'b0;
   logic [`HIPS_ADDR_W-1:0] addr_i = 4'h0;
   logic [`HIPS_DATA_W-1:0] wdata_i = 8'h00;
   logic                    wr_i = 1'b0;
   logic                    rd_i = 1'b0;
   logic [`HIPS_DATA_W-1:0] rdata_o;
   logic                    sel, bprst, pa, pb, flt_l, pg_l, rst_l;
   logic                    flt_o, flt_oe, pg_o, pg_oe, rst_o, rst_oe, led_o, led_oe;
   logic                    be, chg, gnd, sw12, swvee, hold;
   logic [`HIPS_NSUP-1:0]   disch;
   logic [15:0]             outs;
   logic [7:0]              d;
   int                      n_errors = 0;
   int                      compares = 0;
   int                      cnt;

   assign outs = {2'h0, disch, flt_oe, pg_oe, rst_oe, led_oe, be, chg, gnd, sw12, swvee, hold};

   always #10 clk_i = !clk_i;

   hips_backplane i_hips_backplane
   (
      .clk_i(clk_i), .off_req_i(off_req), .bp_reset_req_i(bp_req),
      .present_a_i(pres_a), .present_b_i(pres_b),
      .fault_drv_i(flt_o), .fault_oe_i(flt_oe), .pg_drv_i(pg_o), .pg_oe_i(pg_oe),
      .rst_drv_i(rst_o), .rst_oe_i(rst_oe), .board_select_line_o(sel),
      .backplane_reset_in_n_o(bprst), .card_present_a_n_o(pa), .card_present_b_n_o(pb),
      .fault_n_o(flt_l), .supplies_good_n_o(pg_l), .board_reset_out_n_o(rst_l)
   );

   hips_top i_hips_top
   (
      .clk_i(clk_i), .rst_i(rst_i), .board_select_line_i(sel),
      .backplane_reset_in_n_i(bprst), .card_present_a_n_i(pa), .card_present_b_n_i(pb),
      .undervolt_i(undervolt_i), .supply_in_tol_i(supply_in_tol_i),
      .overcurrent_i(overcurrent_i), .timer_done_i(timer_done_i),
      .fault_n_i(flt_l), .fault_n_o(flt_o), .fault_n_oe_o(flt_oe),
      .supplies_good_n_i(pg_l), .supplies_good_n_o(pg_o), .supplies_good_n_oe_o(pg_oe),
      .board_reset_out_n_i(rst_l), .board_reset_out_n_o(rst_o),
      .board_reset_out_n_oe_o(rst_oe), .status_led_n_o(led_o), .status_led_n_oe_o(led_oe),
      .bus_isolate_enable_o(be), .gate_charge_o(chg), .gate_ground_o(gnd),
      .switch_12v_on_o(sw12), .switch_vee_on_o(swvee), .timer_hold_o(hold),
      .out_discharge_o(disch), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o)
   );

   // ==========================================================================
   // shared tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= v;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      v = rdata_o;
   endtask

   // counts edges until the breaker trips, bounded
   task automatic wait_trip(input logic [3:0] oc);
      @(posedge clk_i);
      overcurrent_i <= oc;
      cnt = 0;
      while (flt_oe !== 1'b1 && cnt < 3000)
      begin
         @(posedge clk_i);
         #1;
         cnt++;
      end
   endtask

   task automatic report_and_stop();
      if (n_errors == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ==========================================================================
   // scenarios
   task automatic t_power_up();
      check(outs, 16'h3ce1);
      @(posedge clk_i);
      off_req         <= 1'b0;
      supply_in_tol_i <= 4'h7;
      wait_cyc(6);
      check({15'h0000, pg_oe}, 16'h0000);
      check({14'h0000, be, chg}, 16'h0003);
      @(posedge clk_i);
      supply_in_tol_i <= 4'hf;
      wait_cyc(5);
      check(outs, 16'h0116);
   endtask

   task automatic t_pg_deglitch();
      @(posedge clk_i);
      supply_in_tol_i <= 4'hb;
      wait_cyc(400);
      check({15'h0000, pg_oe}, 16'h0001);
      @(posedge clk_i);
      supply_in_tol_i <= 4'hf;
      wait_cyc(5);
      @(posedge clk_i);
      supply_in_tol_i <= 4'hd;
      cnt = 0;
      while (pg_oe !== 1'b0 && cnt < 700)
      begin
         @(posedge clk_i);
         #1;
         cnt++;
      end
      check(16'(cnt >= DG && cnt <= DG + 4), 16'h0001);
      wait_cyc(2);
      check(outs, 16'h00f6);
      @(posedge clk_i);
      supply_in_tol_i <= 4'hf;
      wait_cyc(5);
   endtask

   task automatic t_reset_combine();
      @(posedge clk_i);
      bp_req <= 1'b1;
      wait_cyc(6);
      check({14'h0000, rst_oe, led_oe}, 16'h0003);
      @(posedge clk_i);
      bp_req <= 1'b0;
      wait_cyc(6);
      check({14'h0000, rst_oe, led_oe}, 16'h0000);
      reg_wr(`HIPS_ADDR_CTRL, 8'h02);
      wait_cyc(2);
      check({14'h0000, rst_oe, led_oe}, 16'h0003);
      reg_wr(`HIPS_ADDR_CTRL, 8'h04);
      wait_cyc(2);
      check({14'h0000, rst_oe, led_oe}, 16'h0001);
      reg_wr(`HIPS_ADDR_CTRL, 8'h00);
   endtask

   task automatic t_trip_pin();
      @(posedge clk_i);
      overcurrent_i <= 4'h4;
      wait_cyc(2000);
      check({15'h0000, flt_oe}, 16'h0000);
      @(posedge clk_i);
      timer_done_i <= 1'b1;
      wait_cyc(1000);
      @(posedge clk_i);
      overcurrent_i <= 4'h0;
      wait_cyc(5);
      wait_trip(4'h4);
      check(16'(cnt >= OC && cnt <= OC + 4), 16'h0001);
      check(outs, 16'h3f09);
      wait_cyc(2);
      reg_rd(`HIPS_ADDR_STAT, d);
      check({14'h0000, d[7:6]}, 16'h0002);
      check({15'h0000, d[0]}, 16'h0000);
      @(posedge clk_i);
      overcurrent_i <= 4'h0;
      timer_done_i  <= 1'b0;
      wait_cyc(20);
      check(outs, 16'h3f09);
      @(posedge clk_i);
      off_req <= 1'b1;
      wait_cyc(6);
      @(posedge clk_i);
      off_req <= 1'b0;
      wait_cyc(6);
      check(outs, 16'h0116);
   endtask

   task automatic t_trip_latch();
      reg_wr(`HIPS_ADDR_CTRL, 8'h08);
      @(posedge clk_i);
      timer_done_i  <= 1'b1;
      overcurrent_i <= 4'h8;
      wait_cyc(2000);
      check({15'h0000, flt_oe}, 16'h0000);
      reg_wr(`HIPS_ADDR_CTRL, 8'h00);
      wait_trip(4'h1);
      check({15'h0000, gnd}, 16'h0001);
      reg_rd(`HIPS_ADDR_STAT, d);
      check({14'h0000, d[7:6]}, 16'h0000);
      @(posedge clk_i);
      overcurrent_i <= 4'h0;
      timer_done_i  <= 1'b0;
      reg_wr(`HIPS_ADDR_CTRL, 8'h01);
      reg_wr(`HIPS_ADDR_CTRL, 8'h00);
      wait_cyc(3);
      check(outs, 16'h0116);
   endtask

   task automatic t_undervolt();
      @(posedge clk_i);
      undervolt_i <= 4'h2;
      wait_cyc(5);
      check(outs, 16'h3d01);
      @(posedge clk_i);
      undervolt_i <= 4'h0;
      wait_cyc(5);
      check(outs, 16'h0116);
   endtask

   task automatic t_status();
      @(posedge clk_i);
      pres_a <= 1'b0;
      pres_b <= 1'b1;
      wait_cyc(4);
      reg_wr(`HIPS_ADDR_STAT, 8'hff);
      reg_rd(`HIPS_ADDR_STAT, d);
      check({8'h00, d}, 16'h0027);
      wait_cyc(1);
      check({8'h00, rdata_o}, 16'h0000);
      reg_rd(`HIPS_ADDR_CTRL, d);
      check({8'h00, d}, 16'h0000);
      reg_rd(4'h7, d);
      check({8'h00, d}, 16'h0000);
   endtask

   // ==========================================================================
   // main sequence and watchdog
   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      wait_cyc(1);
      t_power_up();
      t_pg_deglitch();
      t_reset_combine();
      t_trip_pin();
      t_trip_latch();
      t_undervolt();
      t_status();
      report_and_stop();
   end

   initial
   begin
      #(20 * 40000);
      n_errors++;
      report_and_stop();
   end
endmodule
